/* design/input_sync.sv */
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps

module input_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pin side
  input wire logic i_pin,
  // Clock domain side
  output logic o_level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end
    else
    begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_level <= RST_VAL;
    end
    else if (s2_q == s3_q)
    begin
      o_level <= s2_q;
    end
  end

endmodule : input_sync

/* design/power_fail_fan_supervisor.sv */
// Exhaust fan watchdog and backup-power failure sequencer
//
// Operation
// - A fan fault is declared when no tachometer edge was seen for 128.5 ms since the last one.
// - A fan fault drives the abnormal-condition output high.
// - The fan is never switched; its pulses are watched continuously while powered.
// - A setup flag holds whether a backup power unit is present; a closed contact with the flag clear raises error 10.
// - With a backup unit configured, a high status input means power present and low means failure.
// - The power-ok indicator is lit while power is supplied and off on a reported failure.
// - Specimen load requests are refused while the failure indication is active.
// - Processing continues five minutes after a failure and carries on if power returns in time.
// - Without power at the end of the grace period a power-off error is raised and specimens park.
// - After a power-off error, processing restarts only on restored power plus the resume key.
// - With a dryer fitted, the heater goes off as soon as the failure indication arrives.
`timescale 1ns/1ps
`include "supervisor_params.svh"

module power_fail_fan_supervisor #(
  parameter longint unsigned FAN_TIMEOUT_CYC = `FAN_TIMEOUT_CYC,
  parameter longint unsigned GRACE_CYC = `GRACE_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pins from the fan and the rear terminal block
  input wire logic i_fan_tach,
  input wire logic i_power_status,
  input wire logic i_resume_key,
  // Setup from the main controller
  input wire logic i_setup_we,
  input wire logic i_setup_backup_present,
  input wire logic i_dryer_fitted,
  // Requests from the main controller
  input wire logic i_heater_req,
  input wire logic i_load_req,
  // Status and control outputs
  output logic o_fan_fault,
  output logic o_abnormal,
  output logic [3:0] o_error_code,
  output logic o_power_ok_indicator,
  output logic o_power_fail,
  output logic o_load_grant,
  output logic o_heater_on,
  output logic o_run,
  output logic o_park,
  output logic o_power_off_error,
  output supervisor_pkg::pwr_state_t o_state
);

  import supervisor_pkg::*;

  localparam int FAN_W = $clog2(FAN_TIMEOUT_CYC + 64'(1));
  localparam int GRACE_W = $clog2(GRACE_CYC + 64'(1));
  localparam logic [`IN_COUNT-1:0] RST_VALS = `IN_RST_VAL;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [`IN_COUNT-1:0] pins;
  logic [`IN_COUNT-1:0] sync;

  assign pins[`IN_TACH] = i_fan_tach;
  assign pins[`IN_POWER] = i_power_status;
  assign pins[`IN_RESUME] = i_resume_key;

  genvar gi;
  generate
    for (gi = 0; gi < `IN_COUNT; gi++)
    begin : g_sync
      input_sync #(
        .RST_VAL(RST_VALS[gi])
      ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(pins[gi]),
        .o_level(sync[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Fan timeout monitor
  // ****************************************************************
  // Always running: nothing here can gate or switch the fan
  logic tach_prev_q;
  logic [FAN_W-1:0] fan_cnt_q;
  logic tach_edge;

  assign tach_edge = sync[`IN_TACH] ^ tach_prev_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tach_prev_q <= 1'b0;
    end
    else
    begin
      tach_prev_q <= sync[`IN_TACH];
    end
  end

  // Both edges restart; a 6.25 ms half period leaves wide margin
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      fan_cnt_q <= '0;
    end
    else if (tach_edge)
    begin
      fan_cnt_q <= '0;
    end
    else if (fan_cnt_q != FAN_W'(FAN_TIMEOUT_CYC))
    begin
      fan_cnt_q <= fan_cnt_q + FAN_W'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_fan_fault <= 1'b0;
    end
    else if (tach_edge)
    begin
      o_fan_fault <= 1'b0;
    end
    else if (fan_cnt_q == FAN_W'(FAN_TIMEOUT_CYC - 64'(1)))
    begin
      o_fan_fault <= 1'b1;
    end
  end

  // ****************************************************************
  // Setup flag and wiring check
  // ****************************************************************
  logic backup_cfg_q;
  logic power_fail;
  logic setup_mismatch;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      backup_cfg_q <= 1'b0;
    end
    else if (i_setup_we)
    begin
      backup_cfg_q <= i_setup_backup_present;
    end
  end

  // A closed contact with no unit configured betrays wiring the setup denies
  assign setup_mismatch = !backup_cfg_q && sync[`IN_POWER];
  // Open contact is a failure, but only when a unit is configured
  assign power_fail = backup_cfg_q && !sync[`IN_POWER];

  // ****************************************************************
  // Power-failure sequencer
  // ****************************************************************
  pwr_state_t state_q;
  pwr_state_t state_d;
  logic [GRACE_W-1:0] grace_cnt_q;
  logic resume_prev_q;
  logic resume_press;

  assign resume_press = sync[`IN_RESUME] && !resume_prev_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      resume_prev_q <= 1'b0;
    end
    else
    begin
      resume_prev_q <= sync[`IN_RESUME];
    end
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PWR_NORMAL:
      begin
        if (power_fail)
        begin
          state_d = PWR_GRACE;
        end
      end
      PWR_GRACE:
      begin
        if (!power_fail)
        begin
          state_d = PWR_NORMAL;
        end
        else if (grace_cnt_q == GRACE_W'(GRACE_CYC - 64'(1)))
        begin
          state_d = PWR_OFF_ERR;
        end
      end
      PWR_OFF_ERR:
      begin
        // Key presses while power is still out are ignored
        if (!power_fail && resume_press)
        begin
          state_d = PWR_NORMAL;
        end
      end
      default:
      begin
        state_d = PWR_NORMAL;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q <= PWR_NORMAL;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || state_q != PWR_GRACE)
    begin
      grace_cnt_q <= '0;
    end
    else
    begin
      grace_cnt_q <= grace_cnt_q + GRACE_W'(1);
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_abnormal <= 1'b0;
      o_error_code <= `ERR_NONE;
      o_power_ok_indicator <= 1'b0;
      o_power_fail <= 1'b0;
      o_state <= PWR_NORMAL;
    end
    else
    begin
      o_abnormal <= o_fan_fault || setup_mismatch || (state_q == PWR_OFF_ERR);
      o_error_code <= setup_mismatch ? `ERR_BACKUP_SETUP : `ERR_NONE;
      o_power_ok_indicator <= !power_fail;
      o_power_fail <= power_fail;
      o_state <= state_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_load_grant <= 1'b0;
      o_heater_on <= 1'b0;
    end
    else
    begin
      o_load_grant <= i_load_req && !power_fail && (state_q == PWR_NORMAL);
      // Heater drops on the failure itself, not at the end of grace
      o_heater_on <= i_dryer_fitted && i_heater_req && !power_fail
        && (state_q != PWR_OFF_ERR);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_run <= 1'b1;
      o_park <= 1'b0;
      o_power_off_error <= 1'b0;
    end
    else
    begin
      o_run <= (state_d != PWR_OFF_ERR);
      o_park <= (state_d == PWR_OFF_ERR);
      o_power_off_error <= (state_d == PWR_OFF_ERR);
    end
  end

endmodule : power_fail_fan_supervisor

/* design/supervisor_params.svh */
// Constants for the power-fail and exhaust-fan supervisor
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

// ****************************************************************
// Clock
// ****************************************************************
`define CLK_FREQ_HZ 200000000
`define MS_PER_S 1000
`define S_PER_MIN 60

// ****************************************************************
// Timing
// ****************************************************************
// Fan pulse silence that counts as a fault
`define FAN_TIMEOUT_MS 128.5
// Healthy fan pulse period, for reference only
`define FAN_PULSE_PERIOD_MS 12.5
// Grace period after a power failure
`define GRACE_TIME_MIN 5
// Fan timeout rounds to the nearest whole cycle; grace is exact
`define FAN_TIMEOUT_CYC (64'(`FAN_TIMEOUT_MS * `CLK_FREQ_HZ / `MS_PER_S))
`define GRACE_CYC (64'(`GRACE_TIME_MIN) * 64'(`S_PER_MIN) * 64'(`CLK_FREQ_HZ))

// ****************************************************************
// Error codes and input indices
// ****************************************************************
`define ERR_NONE 4'h0
`define ERR_BACKUP_SETUP 4'hA
`define IN_COUNT 3
`define IN_TACH 0
`define IN_POWER 1
`define IN_RESUME 2
// Reset levels of the three synchronised inputs: power assumed present
`define IN_RST_VAL 3'h2

`endif

/* design/supervisor_pkg.sv */
// Types shared by the supervisor design
package supervisor_pkg;

  // ****************************************************************
  // Power-failure sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    PWR_NORMAL = 3'h1,
    PWR_GRACE = 3'h2,
    PWR_OFF_ERR = 3'h4
  } pwr_state_t;

endpackage : supervisor_pkg

/* sim/fan_ups_model.sv */
// Behavioural exhaust fan tachometer and backup-power contact
`timescale 1ns/1ps

module fan_backup_model #(
  parameter int HALF = 10
) (
  // Bench controls
  input wire logic i_clk,
  input wire logic i_fan_on,
  input wire logic i_closed,
  // Pins toward the block
  output logic o_fan_tach,
  output logic o_power_status
);
  int cnt_q = 0;
  logic tach_q = 1'h0;
  // A stopped fan leaves its pin stuck at the last level, like a stalled rotor
  always @(posedge i_clk)
  begin
    cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
    if (i_fan_on && cnt_q == HALF - 1)
      tach_q <= !tach_q;
  end
  assign o_fan_tach = tach_q;
  assign o_power_status = i_closed;
endmodule : fan_backup_model

/* sim/supervisor_checker.sv */
// Assertion checker for the supervisor outputs
`timescale 1ns/1ps

module supervisor_checker #(
  parameter longint unsigned FAN_TIMEOUT_CYC = 200,
  parameter longint unsigned GRACE_CYC = 500
) (
  // Block inputs
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fan_tach,
  input wire logic i_power_status,
  input wire logic i_resume_key,
  input wire logic i_setup_we,
  input wire logic i_setup_backup_present,
  input wire logic i_dryer_fitted,
  // Block outputs
  input wire logic o_fan_fault,
  input wire logic o_abnormal,
  input wire logic [3:0] o_error_code,
  input wire logic o_power_ok_indicator,
  input wire logic o_power_fail,
  input wire logic o_load_grant,
  input wire logic o_heater_on,
  input wire logic o_run,
  input wire logic o_park,
  input wire logic o_power_off_error,
  input wire supervisor_pkg::pwr_state_t o_state
);
  import supervisor_pkg::*;
  logic tach_q;
  logic cfg_q;
  logic [31:0] quiet_q;
  logic [31:0] grace_q;
  // ****************************************************************
  // Helper state
  // ****************************************************************
  // Silence is counted at the raw pin, so the window allows for the filter delay
  always_ff @(posedge i_clk)
  begin
    tach_q <= i_fan_tach;
    quiet_q <= (i_rst || tach_q != i_fan_tach) ? '0 : quiet_q + 1;
  end
  always_ff @(posedge i_clk)
  begin
    grace_q <= (i_rst || o_state != PWR_GRACE) ? '0 : grace_q + 1;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      cfg_q <= 1'h0;
    else if (i_setup_we)
      cfg_q <= i_setup_backup_present;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ****************************************************************
  // Properties
  // ****************************************************************
  a_fan_quiet_ok: assert property ((quiet_q > 8 && quiet_q < FAN_TIMEOUT_CYC - 8) |->
    !o_fan_fault) else $error("fan fault too early");
  a_fan_silent_fault: assert property (quiet_q > FAN_TIMEOUT_CYC + 10 |-> o_fan_fault)
    else $error("fan fault missing");
  a_abnormal_follows: assert property ((o_fan_fault || o_power_off_error) |=> o_abnormal)
    else $error("abnormal not raised");
  a_setup_mismatch: assert property ((!cfg_q && i_power_status) [*8] |->
    o_error_code == 4'hA) else $error("error 10 missing");
  a_power_fail_seen: assert property ((cfg_q && !i_power_status) [*8] |-> o_power_fail)
    else $error("power failure missed");
  a_lamp_tracks: assert property (!$past(i_rst) |-> o_power_ok_indicator == !o_power_fail)
    else $error("lamp wrong");
  a_load_refused: assert property ((o_power_fail || o_state != PWR_NORMAL) [*2] |->
    !o_load_grant) else $error("load granted in failure");
  a_grace_length: assert property ($rose(o_park) |-> grace_q >= GRACE_CYC - 3 &&
    grace_q <= GRACE_CYC + 3) else $error("grace length wrong");
  a_park_error: assert property (o_park |-> o_power_off_error && !o_run &&
    !o_load_grant && !o_heater_on) else $error("park without error");
  a_resume_cause: assert property ($fell(o_power_off_error) |-> $past(i_resume_key, 3) &&
    $past(i_power_status, 3)) else $error("resumed without key");
  a_heater_cut: assert property ((i_dryer_fitted && o_power_fail) [*2] |-> !o_heater_on)
    else $error("heater on in failure");
  c_fan_fault: cover property (o_fan_fault);
  c_park: cover property ($rose(o_park));
  c_resume: cover property ($fell(o_power_off_error));
endmodule : supervisor_checker

bind power_fail_fan_supervisor supervisor_checker #(.FAN_TIMEOUT_CYC(FAN_TIMEOUT_CYC),
  .GRACE_CYC(GRACE_CYC)) u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_fan_tach(i_fan_tach),
  .i_power_status(i_power_status), .i_resume_key(i_resume_key), .i_setup_we(i_setup_we),
  .i_setup_backup_present(i_setup_backup_present), .i_dryer_fitted(i_dryer_fitted),
  .o_fan_fault(o_fan_fault), .o_abnormal(o_abnormal), .o_error_code(o_error_code),
  .o_power_ok_indicator(o_power_ok_indicator), .o_power_fail(o_power_fail),
  .o_load_grant(o_load_grant), .o_heater_on(o_heater_on), .o_run(o_run), .o_park(o_park),
  .o_power_off_error(o_power_off_error), .o_state(o_state));

/* sim/test_power_fail_fan_supervisor.sv */
// Self-checking bench for the supervisor
`timescale 1ns/1ps

module test_power_fail_fan_supervisor;
  import supervisor_pkg::*;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic fan_on = 1'h1;
  logic closed = 1'h0;
  logic i_fan_tach;
  logic i_power_status;
  logic i_resume_key = 1'h0;
  logic i_setup_we = 1'h0;
  logic i_setup_backup_present = 1'h0;
  logic i_dryer_fitted = 1'h0;
  logic i_heater_req = 1'h0;
  logic i_load_req = 1'h0;
  logic o_fan_fault, o_abnormal, o_power_ok_indicator, o_power_fail, o_load_grant;
  logic o_heater_on, o_run, o_park, o_power_off_error;
  logic [3:0] o_error_code;
  pwr_state_t o_state;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int cmp_count = 0;
  int seed = 81;
  event snap;
  power_fail_fan_supervisor #(.FAN_TIMEOUT_CYC(200), .GRACE_CYC(500)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_fan_tach(i_fan_tach), .i_power_status(i_power_status),
    .i_resume_key(i_resume_key), .i_setup_we(i_setup_we),
    .i_setup_backup_present(i_setup_backup_present), .i_dryer_fitted(i_dryer_fitted),
    .i_heater_req(i_heater_req), .i_load_req(i_load_req), .o_fan_fault(o_fan_fault),
    .o_abnormal(o_abnormal), .o_error_code(o_error_code),
    .o_power_ok_indicator(o_power_ok_indicator), .o_power_fail(o_power_fail),
    .o_load_grant(o_load_grant), .o_heater_on(o_heater_on), .o_run(o_run), .o_park(o_park),
    .o_power_off_error(o_power_off_error), .o_state(o_state));
  fan_backup_model #(.HALF(10)) u_far (.i_clk(i_clk), .i_fan_on(fan_on), .i_closed(closed),
    .o_fan_tach(i_fan_tach), .o_power_status(i_power_status));
  initial forever #2.5 i_clk = ~i_clk;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic go(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : go
  // Grant and heater bits mean allowed; random requests, and the dryer option, gate them
  task automatic note(input logic [15:0] v);
    go(1);
    {i_load_req, i_heater_req} = 2'($random(seed));
    go(3);
    v[7] = v[7] & i_load_req;
    v[6] = v[6] & i_heater_req & i_dryer_fitted;
    exp_q.push_back(v);
    ->snap;
  endtask : note
  task automatic key();
    i_resume_key = 1'h1;
    go(10);
    i_resume_key = 1'h0;
    go(10);
  endtask : key
  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial forever
  begin
    @(snap);
    check({o_fan_fault, o_abnormal, o_error_code, o_power_ok_indicator, o_power_fail,
      o_load_grant, o_heater_on, o_run, o_park, o_power_off_error, o_state}, exp_q.pop_front());
  end
  initial
  begin
    #100000;
    err_count++;
    finish_test();
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    go(5);
    i_rst = 1'h0;
    go(300);
    note(16'h02E1);
    closed = 1'h1;
    go(10);
    note(16'h6AE1);
    i_setup_we = 1'h1;
    i_setup_backup_present = 1'h1;
    go(1);
    i_setup_we = 1'h0;
    go(10);
    note(16'h02E1);
    fan_on = 1'h0;
    go(250);
    note(16'hC2E1);
    fan_on = 1'h1;
    go(30);
    note(16'h02E1);
    i_dryer_fitted = 1'h1;
    closed = 1'h0;
    go(10);
    note(16'h0122);
    go(100);
    closed = 1'h1;
    go(10);
    note(16'h02E1);
    closed = 1'h0;
    go(520);
    note(16'h411C);
    key();
    note(16'h411C);
    closed = 1'h1;
    go(20);
    note(16'h421C);
    key();
    note(16'h02E1);
    go(5);
    finish_test();
  end
endmodule : test_power_fail_fan_supervisor
